// ### cps_top.sv
// Camera power, ASIC bring-up, key scan and timekeeping controller
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_top #(
    parameter int SETTLE_CYC = `CPS_SETTLE_CYC,
    parameter int SUB_HZ = `CPS_SUB_HZ,
    parameter int CHARGE_SEC = `CPS_CHARGE_SEC,
    parameter int ROWS = 6,
    parameter int COLS = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire cps_pkg::cps_wb_req_t wb_req_i,
    output cps_pkg::cps_wb_rsp_t wb_rsp_o,
    input wire logic battery_present_i,
    input wire logic backup_attached_i,
    input wire logic sub_tick_i,
    input wire logic lens_stowed_i,
    input wire logic [COLS-1:0] scan_in_i,
    output logic [ROWS-1:0] scan_out_o,
    output logic digital_supply_enable_o,
    output logic analog_supply_enable_o,
    output logic panel_supply_enable_o,
    output logic backlight_enable_o,
    output logic lens_stow_req_o,
    output logic main_osc_enable_o,
    output logic backup_charge_n_o,
    output logic [3:0] asic_cfg_o,
    output logic asic_cfg_oe_n_o,
    output logic asic_test_reset_n_o,
    output logic asic_main_reset_n_o,
    input wire logic serial_request_n_i,
    output logic serial_sck_o,
    output logic serial_so_o,
    input wire logic serial_si_i,
    output logic [7:0] display_data_o
);
    localparam int KEYS = ROWS * COLS;

    cps_pkg::cps_state_t state_reg;
    cps_pkg::cps_ctrl_t ctrl_reg;
    logic [31:0] timer_reg;
    logic [3:0] cfg_reg;
    logic link_ok_reg;
    logic link_err_reg;
    logic [7:0] tx_reg;
    logic tx_pend_reg;
    logic [7:0] rx_reg;
    logic [2:0] row_reg;
    logic [7:0] dwell_reg;
    logic [KEYS-1:0] keys_flat;
    logic pw_prev_reg;
    logic pw_press;
    logic scan_en;
    logic [15:0] sub_cnt_reg;
    logic [31:0] time_reg;
    logic sec_tick;
    logic attach_prev_reg;
    logic [31:0] charge_reg;
    logic [7:0] bl_cnt_reg;
    logic ser_start;
    logic [7:0] ser_tx;
    logic ser_busy;
    logic ser_done;
    logic [7:0] ser_rx;
    logic ser_sent_reg;
    logic req_sync_reg;
    logic wb_hit;

    // ==========================================================
    // Key matrix scan, one active-low row at a time
    assign scan_en = battery_present_i;
    assign pw_press = keys_flat[0] & ~pw_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            row_reg <= 3'h0;
            dwell_reg <= 8'h00;
            pw_prev_reg <= 1'b0;
        end else if (ce_i) begin
            pw_prev_reg <= keys_flat[0];
            if (scan_en) begin
                if (dwell_reg == 8'(`CPS_SCAN_DWELL - 1)) begin
                    dwell_reg <= 8'h00;
                    row_reg <= (row_reg == 3'(ROWS - 1)) ? 3'h0 : row_reg + 3'h1;
                end else begin
                    dwell_reg <= dwell_reg + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_out_o <= '1;
        end else if (ce_i) begin
            for (int r = 0; r < ROWS; r++) begin
                scan_out_o[r] <= ~(scan_en && row_reg == 3'(r));
            end
        end
    end

    generate
        for (genvar r = 0; r < ROWS; r++) begin : gen_row
            logic [COLS-1:0] row_q;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    row_q <= '0;
                end else if (ce_i && scan_en && row_reg == 3'(r)
                             && dwell_reg == 8'(`CPS_SCAN_DWELL - 1)) begin
                    row_q <= ~scan_in_i;
                end
            end
            assign keys_flat[r*COLS +: COLS] = row_q;
        end
    endgenerate

    // ==========================================================
    // Timekeeping on subclock ticks and backup cell charging
    assign sec_tick = sub_tick_i && sub_cnt_reg == 16'(SUB_HZ - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_cnt_reg <= 16'h0000;
            time_reg <= 32'h0000_0000;
        end else if (ce_i && sub_tick_i) begin
            sub_cnt_reg <= sec_tick ? 16'h0000 : sub_cnt_reg + 16'h0001;
            if (sec_tick) begin
                time_reg <= time_reg + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            attach_prev_reg <= 1'b0;
            charge_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            attach_prev_reg <= backup_attached_i;
            if (backup_attached_i && !attach_prev_reg) begin
                charge_reg <= 32'(CHARGE_SEC);
            end else if (!backup_attached_i) begin
                charge_reg <= 32'h0000_0000;
            end else if (sec_tick && charge_reg != 32'h0000_0000) begin
                charge_reg <= charge_reg - 32'h0000_0001;
            end
        end
    end

    assign backup_charge_n_o = !(backup_attached_i && charge_reg != 32'h0000_0000);

    // ==========================================================
    // Power sequence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= cps_pkg::CPS_OFF;
            timer_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            timer_reg <= timer_reg + 32'h0000_0001;
            if (!battery_present_i) begin
                state_reg <= cps_pkg::CPS_OFF;
            end else begin
                case (state_reg)
                    cps_pkg::CPS_OFF: begin
                        if (pw_press) begin
                            state_reg <= cps_pkg::CPS_SETTLE;
                            timer_reg <= 32'h0000_0000;
                        end
                    end
                    cps_pkg::CPS_SETTLE: begin
                        if (timer_reg == 32'(SETTLE_CYC - 1)) begin
                            state_reg <= cps_pkg::CPS_CFG;
                        end
                    end
                    cps_pkg::CPS_CFG: begin
                        state_reg <= cps_pkg::CPS_RESET;
                        timer_reg <= 32'h0000_0000;
                    end
                    cps_pkg::CPS_RESET: begin
                        if (timer_reg == 32'(`CPS_RST_HOLD_CYC - 1)) begin
                            state_reg <= cps_pkg::CPS_CHECK;
                        end
                    end
                    cps_pkg::CPS_CHECK: begin
                        if (ser_done) begin
                            state_reg <= (ser_rx == `CPS_CHECK_ACK) ?
                                         cps_pkg::CPS_RUN : cps_pkg::CPS_STOW;
                        end
                    end
                    cps_pkg::CPS_RUN: begin
                        if (pw_press || ctrl_reg.off_req) begin
                            state_reg <= cps_pkg::CPS_STOW;
                        end
                    end
                    cps_pkg::CPS_STOW: begin
                        if (lens_stowed_i) begin
                            state_reg <= cps_pkg::CPS_SHUT;
                        end
                    end
                    cps_pkg::CPS_SHUT: begin
                        state_reg <= cps_pkg::CPS_OFF;
                    end
                    default: begin
                        state_reg <= cps_pkg::CPS_OFF;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Supply enables and ASIC reset pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            digital_supply_enable_o <= 1'b0;
            analog_supply_enable_o <= 1'b0;
            panel_supply_enable_o <= 1'b0;
            lens_stow_req_o <= 1'b0;
            main_osc_enable_o <= 1'b0;
            asic_test_reset_n_o <= 1'b0;
            asic_main_reset_n_o <= 1'b0;
            asic_cfg_o <= `CPS_CFG_RESET;
            asic_cfg_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            main_osc_enable_o <= battery_present_i && state_reg != cps_pkg::CPS_OFF;
            digital_supply_enable_o <= battery_present_i && state_reg != cps_pkg::CPS_OFF
                                       && state_reg != cps_pkg::CPS_SHUT;
            if (battery_present_i && state_reg == cps_pkg::CPS_RUN) begin
                analog_supply_enable_o <= ctrl_reg.preview & ~ctrl_reg.playback;
                panel_supply_enable_o <= ctrl_reg.panel;
            end else if (!battery_present_i || state_reg == cps_pkg::CPS_OFF
                         || state_reg == cps_pkg::CPS_SHUT) begin
                analog_supply_enable_o <= 1'b0;
                panel_supply_enable_o <= 1'b0;
            end else if (state_reg == cps_pkg::CPS_SETTLE) begin
                analog_supply_enable_o <= 1'b1;
            end
            lens_stow_req_o <= state_reg == cps_pkg::CPS_STOW;
            if (state_reg == cps_pkg::CPS_CFG) begin
                asic_cfg_o <= cfg_reg;
                asic_cfg_oe_n_o <= 1'b0;
            end else if (state_reg == cps_pkg::CPS_OFF) begin
                asic_cfg_oe_n_o <= 1'b1;
            end
            asic_test_reset_n_o <= state_reg != cps_pkg::CPS_RESET;
            asic_main_reset_n_o <= state_reg != cps_pkg::CPS_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bl_cnt_reg <= 8'h00;
            backlight_enable_o <= 1'b0;
        end else if (ce_i) begin
            if (!panel_supply_enable_o || state_reg != cps_pkg::CPS_RUN || !ctrl_reg.panel
                || !battery_present_i) begin
                bl_cnt_reg <= 8'h00;
                backlight_enable_o <= 1'b0;
            end else if (bl_cnt_reg == 8'(`CPS_BL_DELAY - 1)) begin
                backlight_enable_o <= 1'b1;
            end else begin
                bl_cnt_reg <= bl_cnt_reg + 8'h01;
            end
        end
    end

    // ==========================================================
    // Serial exchange with the ASIC
    always_comb begin
        ser_start = 1'b0;
        ser_tx = tx_reg;
        if (!ser_busy && !ser_done) begin
            if (state_reg == cps_pkg::CPS_CHECK && !ser_sent_reg) begin
                ser_start = 1'b1;
                ser_tx = `CPS_CHECK_CMD;
            end else if (state_reg == cps_pkg::CPS_RUN && tx_pend_reg) begin
                ser_start = 1'b1;
            end else if (state_reg == cps_pkg::CPS_RUN && req_sync_reg) begin
                ser_start = 1'b1;
                ser_tx = {4'h0, ctrl_reg};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ser_sent_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            link_ok_reg <= 1'b0;
            link_err_reg <= 1'b0;
            rx_reg <= 8'h00;
        end else if (ce_i) begin
            req_sync_reg <= ~serial_request_n_i;
            if (state_reg != cps_pkg::CPS_CHECK) begin
                ser_sent_reg <= 1'b0;
            end else if (ser_start) begin
                ser_sent_reg <= 1'b1;
            end
            if (state_reg == cps_pkg::CPS_SETTLE) begin
                link_ok_reg <= 1'b0;
                link_err_reg <= 1'b0;
            end else if (state_reg == cps_pkg::CPS_CHECK && ser_done) begin
                link_ok_reg <= ser_rx == `CPS_CHECK_ACK;
                link_err_reg <= ser_rx != `CPS_CHECK_ACK;
            end
            if (ser_done) begin
                rx_reg <= ser_rx;
            end
        end
    end

    cps_serial #(
        .DIV(`CPS_SCK_DIV)
    ) u_serial (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(ser_start),
        .tx_i(ser_tx),
        .busy_o(ser_busy),
        .done_o(ser_done),
        .rx_o(ser_rx),
        .sck_o(serial_sck_o),
        .so_o(serial_so_o),
        .si_i(serial_si_i)
    );

    // ==========================================================
    // Wishbone register slave, one wait state
    assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `CPS_CTRL_RESET;
            cfg_reg <= `CPS_CFG_RESET;
            display_data_o <= `CPS_DISP_RESET;
            tx_reg <= 8'h00;
            tx_pend_reg <= 1'b0;
        end else if (ce_i) begin
            if (wb_hit && wb_req_i.we && wb_req_i.sel[0]) begin
                case (wb_req_i.adr)
                    `CPS_ADR_CTRL: ctrl_reg <= wb_req_i.dat[3:0];
                    `CPS_ADR_CFG: cfg_reg <= wb_req_i.dat[3:0];
                    `CPS_ADR_DISP: display_data_o <= wb_req_i.dat[7:0];
                    `CPS_ADR_TX: tx_reg <= wb_req_i.dat[7:0];
                    default: begin
                    end
                endcase
            end
            if (wb_hit && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == `CPS_ADR_TX) begin
                tx_pend_reg <= 1'b1;
            end else if (ser_start && state_reg == cps_pkg::CPS_RUN && tx_pend_reg) begin
                tx_pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_rsp_o <= '0;
        end else if (ce_i) begin
            wb_rsp_o.ack <= wb_hit;
            wb_rsp_o.dat <= 32'h0000_0000;
            if (wb_hit && !wb_req_i.we) begin
                case (wb_req_i.adr)
                    `CPS_ADR_CTRL: wb_rsp_o.dat <= {28'h0, ctrl_reg};
                    `CPS_ADR_STATUS: wb_rsp_o.dat <= {24'h0, !backup_charge_n_o,
                        link_err_reg, link_ok_reg, ser_busy, state_reg};
                    `CPS_ADR_TX: wb_rsp_o.dat <= {23'h0, tx_pend_reg, tx_reg};
                    `CPS_ADR_RX: wb_rsp_o.dat <= {24'h0, rx_reg};
                    `CPS_ADR_KEYS_LO: wb_rsp_o.dat <= keys_flat[31:0];
                    `CPS_ADR_KEYS_HI: wb_rsp_o.dat <= 32'(keys_flat[KEYS-1:32]);
                    `CPS_ADR_DISP: wb_rsp_o.dat <= {24'h0, display_data_o};
                    `CPS_ADR_CFG: wb_rsp_o.dat <= {28'h0, cfg_reg};
                    `CPS_ADR_TIME: wb_rsp_o.dat <= time_reg;
                    default: wb_rsp_o.dat <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ### cps_defines.svh
// Constants for the camera power sequencer: offsets, fields, resets, timing
//
// Contract
// - Power-on raises digital and analog supply enables together.
// - About 100 ms after digital enable, set ASIC configuration, then assert both resets.
// - After ASIC reset, start serial exchange and confirm the system can run.
// - Gather keys and conditions, send mode settings to ASIC and segment display.
// - Drive scan outputs one at a time, sample inputs, decode each crossing.
// - Live preview keeps the analog supply enable high.
// - Playback drives the analog supply enable low.
// - Panel supply enable goes high first, backlight enable after it.
// - At power-off, stow the lens first, then drop all four enables; backlight enable drops when stowing begins.
// - After shutdown, stop main oscillator and keep running on the subclock.
// - With switch off and battery present, timekeeping and key scan continue.
// - On backup cell, main oscillator stays stopped and only timekeeping runs.
// - Charge the backup cell for ten hours from its attachment.
// - Supply and backlight enables are active high; ASIC main reset active low.
// - Serial link: controller clock, one data out, one in, active-low request.
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH

// ==========================================================
// Register offsets
`define CPS_ADR_CTRL 8'h00
`define CPS_ADR_STATUS 8'h04
`define CPS_ADR_TX 8'h08
`define CPS_ADR_RX 8'h0c
`define CPS_ADR_KEYS_LO 8'h10
`define CPS_ADR_KEYS_HI 8'h14
`define CPS_ADR_DISP 8'h18
`define CPS_ADR_CFG 8'h1c
`define CPS_ADR_TIME 8'h20

// ==========================================================
// Fields and reset values
`define CPS_CTRL_PREVIEW 0
`define CPS_CTRL_PLAYBACK 1
`define CPS_CTRL_PANEL 2
`define CPS_CTRL_OFF_REQ 3
`define CPS_CTRL_RESET 4'h0
`define CPS_CFG_RESET 4'h3
`define CPS_DISP_RESET 8'h00
`define CPS_CHECK_CMD 8'ha5
`define CPS_CHECK_ACK 8'h5a

// ==========================================================
// Timing
`define CPS_CLK_MHZ 100
`define CPS_SETTLE_MS 100
`define CPS_SETTLE_CYC (`CPS_SETTLE_MS * 1000 * `CPS_CLK_MHZ)
`define CPS_RST_HOLD_NS 2000
`define CPS_RST_HOLD_CYC ((`CPS_RST_HOLD_NS * `CPS_CLK_MHZ + 999) / 1000)
`define CPS_SUB_HZ 32768
`define CPS_CHARGE_HOURS 10
`define CPS_CHARGE_SEC (`CPS_CHARGE_HOURS * 3600)
`define CPS_SCAN_DWELL 64
`define CPS_BL_DELAY 16
`define CPS_SCK_DIV 8

`endif

// ### cps_pkg.sv
// Types shared by the camera power sequencer
package cps_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cps_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cps_wb_rsp_t;

    typedef struct packed {
        logic off_req;
        logic panel;
        logic playback;
        logic preview;
    } cps_ctrl_t;

    typedef enum logic [3:0] {
        CPS_OFF = 4'h0,
        CPS_SETTLE = 4'h1,
        CPS_CFG = 4'h2,
        CPS_RESET = 4'h3,
        CPS_CHECK = 4'h4,
        CPS_RUN = 4'h5,
        CPS_STOW = 4'h6,
        CPS_SHUT = 4'h7
    } cps_state_t;

endpackage

// ### cps_serial.sv
// Byte shifter for the serial link to the image ASIC
`timescale 1ns/1ps
`include "cps_defines.svh"
module cps_serial #(
    parameter int DIV = `CPS_SCK_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [7:0] tx_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rx_o,
    output logic sck_o,
    output logic so_o,
    input wire logic si_i
);
    logic [7:0] sh_reg;
    logic [2:0] bit_reg;
    logic [7:0] cnt_reg;

    // ==========================================================
    // Shift engine: data changes on falling clock, sampled on rising
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rx_o <= 8'h00;
            sck_o <= 1'b1;
            so_o <= 1'b1;
            sh_reg <= 8'h00;
            bit_reg <= 3'h0;
            cnt_reg <= 8'h00;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (!busy_o) begin
                if (start_i) begin
                    busy_o <= 1'b1;
                    sh_reg <= tx_i;
                    so_o <= tx_i[7];
                    sck_o <= 1'b0;
                    cnt_reg <= 8'h00;
                    bit_reg <= 3'h0;
                end
            end else if (cnt_reg == 8'(DIV - 1)) begin
                cnt_reg <= 8'h00;
                if (!sck_o) begin
                    sck_o <= 1'b1;
                    sh_reg <= {sh_reg[6:0], si_i};
                end else if (bit_reg == 3'h7) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    rx_o <= sh_reg;
                    so_o <= 1'b1;
                end else begin
                    bit_reg <= bit_reg + 3'h1;
                    sck_o <= 1'b0;
                    so_o <= sh_reg[7];
                end
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
endmodule

// ### cps_asic_model.sv
// Image ASIC model: serial link responder and configuration capture
`timescale 1ns/1ps
module cps_asic_model #(
    parameter logic [7:0] ANSWER = 8'h5a
) (
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic so_i,
    input wire logic main_reset_n_i,
    input wire logic [3:0] cfg_i,
    output logic si_o,
    output logic [3:0] cfg_seen_o,
    output logic [7:0] rx_byte_o
);
    logic sck_q;
    logic [7:0] tx_sh;
    // ==========
    // Serial exchange, MSB first, data changes on falling sck
    always_ff @(posedge clk_i) begin
        sck_q <= sck_i;
        if (!main_reset_n_i) begin
            cfg_seen_o <= cfg_i;
            si_o <= 1'b1;
            tx_sh <= ANSWER;
        end else if (sck_q && !sck_i) begin
            si_o <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
        end else if (!sck_q && sck_i) begin
            rx_byte_o <= {rx_byte_o[6:0], so_i};
        end
    end
endmodule

// ### cps_top_assertions.sv
// Checker for the camera power sequencer ports
`timescale 1ns/1ps
module cps_top_assertions #(
    parameter int ROWS = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cps_pkg::cps_wb_rsp_t wb_rsp_o,
    input wire logic battery_present_i,
    input wire logic lens_stowed_i,
    input wire logic [ROWS-1:0] scan_out_o,
    input wire logic digital_supply_enable_o,
    input wire logic analog_supply_enable_o,
    input wire logic panel_supply_enable_o,
    input wire logic backlight_enable_o,
    input wire logic main_osc_enable_o,
    input wire logic asic_cfg_oe_n_o,
    input wire logic asic_test_reset_n_o,
    input wire logic asic_main_reset_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [8:0] low_cnt;
    // ==========
    // Cycles the ASIC reset has been held low
    always_ff @(posedge clk_i) begin
        if (rst_i || asic_main_reset_n_o) low_cnt <= 9'h000;
        else if (low_cnt != 9'h1ff) low_cnt <= low_cnt + 9'h001;
    end
    sequence s_panel_up;
        $rose(panel_supply_enable_o);
    endsequence
    sequence s_shutdown;
        $fell(digital_supply_enable_o);
    endsequence
    a_power_pair: assert property ($rose(digital_supply_enable_o) |-> analog_supply_enable_o)
        else $error("analog enable not raised with digital");
    a_cfg_in_reset: assert property (!asic_main_reset_n_o && digital_supply_enable_o
        |-> !asic_cfg_oe_n_o) else $error("config port idle during reset");
    a_reset_pair: assert property (asic_test_reset_n_o == asic_main_reset_n_o)
        else $error("reset lines differ");
    a_reset_hold: assert property ($rose(asic_main_reset_n_o) && digital_supply_enable_o
        |-> low_cnt >= 9'd199) else $error("reset hold too short");
    a_panel_first: assert property (s_panel_up |-> !backlight_enable_o [*8])
        else $error("backlight early");
    a_bl_needs_panel: assert property (backlight_enable_o |-> panel_supply_enable_o)
        else $error("backlight without panel");
    a_off_all: assert property (s_shutdown |-> !analog_supply_enable_o
        && !panel_supply_enable_o && !backlight_enable_o) else $error("enables left on");
    a_stow_first: assert property ((s_shutdown and battery_present_i)
        |-> $past(lens_stowed_i, 2)) else $error("shutdown before stow");
    a_osc_stop: assert property (s_shutdown |-> ##[0:4] !main_osc_enable_o)
        else $error("main oscillator left running");
    a_bat_off: assert property (!battery_present_i |=> !digital_supply_enable_o)
        else $error("supplies on without battery");
    a_scan_one: assert property (battery_present_i |-> $countones(~scan_out_o) <= 1)
        else $error("several rows driven");
    a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
endmodule
bind cps_top cps_top_assertions #(.ROWS(ROWS)) u_cps_top_assertions (.clk_i, .rst_i,
    .wb_rsp_o, .battery_present_i, .lens_stowed_i, .scan_out_o, .digital_supply_enable_o,
    .analog_supply_enable_o, .panel_supply_enable_o, .backlight_enable_o,
    .main_osc_enable_o, .asic_cfg_oe_n_o, .asic_test_reset_n_o, .asic_main_reset_n_o);

// ### test_cps_top.sv
// Testbench for the camera power sequencer
`timescale 1ns/1ps
module test_cps_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bat = 1'b1, bkp = 1'b0, tick = 1'b0, stowed = 1'b0, kp = 1'b0, serial_request_n_n = 1'b1;
    logic [2:0] kr = 3'h0, kc = 3'h0;
    cps_pkg::cps_wb_req_t rq = '0;
    cps_pkg::cps_wb_rsp_t rs;
    logic [5:0] so;
    logic [6:0] si;
    logic dig, ana, pan, bl, stw, osc, chg_n, oe_n, trn, mrn, sck, sdo, sdi;
    logic [3:0] cfg, cfs;
    logic [7:0] disp, rxb;
    logic [31:0] q, t0;
    int bad_count = 0, num_checks = 0, n;
    always #5 clk_i = ~clk_i;
    // Key matrix: pressed key pulls its column low while its row is driven
    assign si = (kp && !so[kr]) ? ~(7'h01 << kc) : 7'h7f;
    cps_top #(.SETTLE_CYC(50), .SUB_HZ(4), .CHARGE_SEC(3)) u_cps_top (.clk_i, .rst_i,
        .ce_i(1'b1), .wb_req_i(rq), .wb_rsp_o(rs), .battery_present_i(bat),
        .backup_attached_i(bkp), .sub_tick_i(tick), .lens_stowed_i(stowed), .scan_in_i(si),
        .scan_out_o(so), .digital_supply_enable_o(dig), .analog_supply_enable_o(ana),
        .panel_supply_enable_o(pan), .backlight_enable_o(bl), .lens_stow_req_o(stw),
        .main_osc_enable_o(osc), .backup_charge_n_o(chg_n), .asic_cfg_o(cfg),
        .asic_cfg_oe_n_o(oe_n), .asic_test_reset_n_o(trn), .asic_main_reset_n_o(mrn),
        .serial_request_n_i(serial_request_n_n), .serial_sck_o(sck), .serial_so_o(sdo),
        .serial_si_i(sdi), .display_data_o(disp));
    cps_asic_model u_cps_asic_model (.clk_i, .sck_i(sck), .so_i(sdo), .main_reset_n_i(mrn),
        .cfg_i(cfg), .si_o(sdi), .cfg_seen_o(cfs), .rx_byte_o(rxb));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic lim(input int k, input int m);
        if (k >= m) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        rq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        for (k = 0; k < 50 && rs.ack !== 1'b1; k++) @(posedge clk_i);
        q = rs.dat;
        lim(k, 50);
        rq <= '0;
        @(posedge clk_i);
    endtask
    task automatic ticks(input int m);
        repeat (m) begin
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({dig, ana, pan, bl, oe_n}, 32'h1);
        wb(1'b0, 8'h24, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 8'h1c, 32'h0);
        chk(q, 32'h3);
        wb(1'b1, 8'h1c, 32'h5);
        kp <= 1'b1;
        for (n = 0; n < 2000 && dig !== 1'b1; n++) @(posedge clk_i);
        lim(n, 2000);
        chk(ana, 1'b1);
        kp <= 1'b0;
        q = 32'h0;
        for (n = 0; n < 300 && q[3:0] !== 4'h5; n++) wb(1'b0, 8'h04, 32'h0);
        lim(n, 300);
        chk(q[5], 1'b1);
        chk(rxb, 8'ha5);
        chk({trn, mrn}, 2'h3);
        chk(cfs, 4'h5);
        wb(1'b1, 8'h00, 32'h1);
        chk(ana, 1'b1);
        wb(1'b1, 8'h00, 32'h3);
        chk(ana, 1'b0);
        wb(1'b1, 8'h00, 32'h7);
        for (n = 0; n < 100 && bl !== 1'b1; n++) @(posedge clk_i);
        lim(n, 100);
        chk(pan, 1'b1);
        wb(1'b1, 8'h18, 32'h3c);
        chk(disp, 8'h3c);
        wb(1'b1, 8'h08, 32'h96);
        repeat (200) @(posedge clk_i);
        chk(rxb, 8'h96);
        serial_request_n_n <= 1'b0;
        @(posedge clk_i);
        serial_request_n_n <= 1'b1;
        repeat (200) @(posedge clk_i);
        chk(rxb, 8'h07);
        {kr, kc, kp} <= {3'h2, 3'h3, 1'b1};
        repeat (800) @(posedge clk_i);
        wb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h20000);
        kp <= 1'b0;
        repeat (800) @(posedge clk_i);
        wb(1'b1, 8'h00, 32'h8);
        for (n = 0; n < 100 && stw !== 1'b1; n++) @(posedge clk_i);
        lim(n, 100);
        chk(dig, 1'b1);
        stowed <= 1'b1;
        for (n = 0; n < 100 && (dig !== 1'b0 || osc !== 1'b0); n++) @(posedge clk_i);
        lim(n, 100);
        chk({ana, pan, bl}, 3'h0);
        bkp <= 1'b1;
        @(posedge clk_i);
        @(posedge clk_i);
        chk(chg_n, 1'b0);
        wb(1'b0, 8'h20, 32'h0);
        t0 = q;
        ticks(8);
        wb(1'b0, 8'h20, 32'h0);
        chk(q - t0, 32'h2);
        ticks(8);
        chk(chg_n, 1'b1);
        bat <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({so, dig, osc}, 8'hfc);
        tally_and_finish();
    end
endmodule
